//--- hdl/acs_pkg.sv
// Constants and types shared by the converter sequencer and its clock generator
// Notes on behaviour
// - A conversion trigger comes from the software start bit or a timer event.
// - Sequence, repeat-single and repeat-sequence operation chosen by the sequence mode field.
// - In those modes a trigger while busy halts conversions until enable and power are both cleared and set again.
// - After such a halt the timer overflow flag is not to be trusted.
// - Recovery: clear enable and power, then set power, then enable, then restart.
// - Clock select 11 routes the sub-main clock to the converter.
// - Leaving gated sub-main clock hangs the converter at divide 3, 5 or 7.
// - That hang clears only by power-up clear, power-on or brown-out reset.
// - Sample mode 0 is extended sampling, timed by the sample-hold input.
// - Sample mode 1 is pulse sampling, timed by an internal counter.
package acs_pkg;

   localparam int CHAN_W = 4;
   localparam int DATA_W = 12;
   localparam int TICK_W = 8;

   localparam logic [1:0] CLK_SEL_SUB_MAIN = 2'h3;
   localparam logic [2:0] DIV_BY_3 = 3'h2;
   localparam logic [2:0] DIV_BY_5 = 3'h4;
   localparam logic [2:0] DIV_BY_7 = 3'h6;

   localparam logic [TICK_W-1:0] CONV_CLOCKS = 8'h0D;
   localparam logic [TICK_W-1:0] TICK_RESET = 8'h00;
   localparam logic [CHAN_W-1:0] CHAN_RESET = 4'h0;
   localparam logic [DATA_W-1:0] DATA_RESET = 12'h000;

   typedef enum logic [1:0] {
      SEQ_SINGLE = 2'b00,
      SEQ_CHANNELS = 2'b01,
      SEQ_REPEAT_SINGLE = 2'b10,
      SEQ_REPEAT_CHANNELS = 2'b11
   } acs_seq_mode_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WAIT_TRIG = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_CONVERT = 3'b011,
      ST_DONE = 3'b100,
      ST_HALTED = 3'b101
   } acs_state_t;

   typedef struct packed {
      logic converter_power_on;
      logic conversion_enable;
      logic trigger_from_timer;
      logic sample_pulse_mode_select;
      logic [1:0] conversion_sequence_mode;
      logic [CHAN_W-1:0] start_channel;
      logic [CHAN_W-1:0] end_channel;
      logic [TICK_W-1:0] sample_clocks;
   } acs_ctrl_t;

   typedef struct packed {
      logic sub_main_clock_gate_off;
      logic [1:0] converter_clock_select;
      logic [2:0] converter_clock_divider;
   } acs_clk_cfg_t;

endpackage

//--- hdl/acs_clock_gen.sv
// Converter clock selection, division and clock-switch hang
`timescale 1ns/100ps
module acs_clock_gen
   import acs_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire acs_clk_cfg_t cfg_i,
   input wire logic [3:0] source_tick_i,
   output logic converter_clock_o,
   output logic converter_hung_o
);

   logic [2:0] div_count;
   logic [2:0] next_div_count;
   logic [1:0] prev_select;
   logic hung;
   logic next_hung;
   logic src_tick;
   logic tick;

   always_comb
   begin
      // Index 3 is the sub-main clock
      src_tick = source_tick_i[cfg_i.converter_clock_select];
      tick = 1'b0;
      next_div_count = div_count;
      next_hung = hung;
      if (prev_select == CLK_SEL_SUB_MAIN && cfg_i.converter_clock_select != CLK_SEL_SUB_MAIN
         && cfg_i.sub_main_clock_gate_off
         && (cfg_i.converter_clock_divider == DIV_BY_3
         || cfg_i.converter_clock_divider == DIV_BY_5
         || cfg_i.converter_clock_divider == DIV_BY_7))
      begin
         next_hung = 1'b1;
      end
      if (src_tick && !hung)
      begin
         if (div_count >= cfg_i.converter_clock_divider)
         begin
            next_div_count = 3'h0;
            tick = 1'b1;
         end
         else
         begin
            next_div_count = div_count + 3'h1;
         end
      end
   end

   // Hang is released by reset only
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         div_count <= 3'h0;
         prev_select <= 2'h0;
         hung <= 1'b0;
         converter_clock_o <= 1'b0;
      end
      else
      begin
         div_count <= next_div_count;
         prev_select <= cfg_i.converter_clock_select;
         hung <= next_hung;
         converter_clock_o <= tick;
      end
   end

   assign converter_hung_o = hung;

endmodule

//--- hdl/acs_sequencer.sv
// Conversion sequencer: triggers, sampling, channel sequencing and halt
`timescale 1ns/100ps
module acs_sequencer
   import acs_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire acs_ctrl_t ctrl_i,
   input wire acs_clk_cfg_t clk_cfg_i,
   input wire logic [3:0] source_tick_i,
   input wire logic software_start_conversion_i,
   input wire logic timer_trigger_i,
   input wire logic sample_hold_input_i,
   input wire logic [DATA_W-1:0] analog_data_i,
   input wire logic result_read_i,
   output logic conversion_busy_flag_o,
   output logic result_valid_o,
   output logic [DATA_W-1:0] result_data_o,
   output logic [CHAN_W-1:0] result_channel_o,
   output logic [CHAN_W-1:0] current_channel_o,
   output logic conversion_timer_overflow_flag_o,
   output logic halted_o,
   output logic converter_hung_o
);

   acs_state_t state;
   acs_state_t next_state;
   logic [TICK_W-1:0] tick_count;
   logic [TICK_W-1:0] next_tick_count;
   logic [CHAN_W-1:0] channel;
   logic [CHAN_W-1:0] next_channel;
   logic [DATA_W-1:0] next_result_data;
   logic [CHAN_W-1:0] next_result_channel;
   logic next_result_valid;
   logic unread;
   logic next_unread;
   logic overflow;
   logic next_overflow;
   logic conv_tick;
   logic trigger;
   logic busy;
   logic multi_mode;
   logic last_channel;
   logic sample_end;

   acs_clock_gen u_clock_gen (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .cfg_i(clk_cfg_i),
      .source_tick_i(source_tick_i),
      .converter_clock_o(conv_tick),
      .converter_hung_o(converter_hung_o)
   );

   always_comb
   begin
      trigger = ctrl_i.trigger_from_timer ? timer_trigger_i
                                          : software_start_conversion_i;
      busy = (state == ST_SAMPLE) || (state == ST_CONVERT);
      multi_mode = (ctrl_i.conversion_sequence_mode != SEQ_SINGLE);
      last_channel = (channel == ctrl_i.end_channel);
      if (ctrl_i.sample_pulse_mode_select)
      begin
         sample_end = conv_tick && (tick_count >= ctrl_i.sample_clocks);
      end
      else
      begin
         sample_end = !sample_hold_input_i;
      end
   end

   always_comb
   begin
      next_state = state;
      next_tick_count = tick_count;
      next_channel = channel;
      next_result_data = result_data_o;
      next_result_channel = result_channel_o;
      next_result_valid = 1'b0;
      next_unread = unread;
      next_overflow = overflow;
      if (result_read_i)
      begin
         next_unread = 1'b0;
         next_overflow = 1'b0;
      end
      case (state)
         ST_IDLE:
         begin
            next_channel = ctrl_i.start_channel;
            if (ctrl_i.converter_power_on && ctrl_i.conversion_enable)
            begin
               next_state = ST_WAIT_TRIG;
            end
         end
         ST_WAIT_TRIG:
         begin
            next_tick_count = TICK_RESET;
            if (!ctrl_i.conversion_enable || !ctrl_i.converter_power_on)
            begin
               next_state = ST_IDLE;
            end
            else if (trigger)
            begin
               next_state = ST_SAMPLE;
            end
         end
         ST_SAMPLE:
         begin
            if (trigger && multi_mode)
            begin
               next_state = ST_HALTED;
            end
            else if (sample_end)
            begin
               next_state = ST_CONVERT;
               next_tick_count = TICK_RESET;
            end
            else if (conv_tick)
            begin
               next_tick_count = tick_count + 8'h01;
            end
         end
         ST_CONVERT:
         begin
            if (trigger && multi_mode)
            begin
               next_state = ST_HALTED;
            end
            else if (conv_tick)
            begin
               next_tick_count = tick_count + 8'h01;
               if (tick_count + 8'h01 >= CONV_CLOCKS)
               begin
                  next_result_data = analog_data_i;
                  next_result_channel = channel;
                  next_result_valid = 1'b1;
                  next_unread = 1'b1;
                  if (unread)
                  begin
                     next_overflow = 1'b1;
                  end
                  case (ctrl_i.conversion_sequence_mode)
                     SEQ_SINGLE:
                     begin
                        next_state = ST_DONE;
                     end
                     SEQ_CHANNELS:
                     begin
                        next_state = last_channel ? ST_DONE : ST_WAIT_TRIG;
                        next_channel = channel + 4'h1;
                     end
                     SEQ_REPEAT_SINGLE:
                     begin
                        next_state = ST_WAIT_TRIG;
                     end
                     default:
                     begin
                        next_state = ST_WAIT_TRIG;
                        next_channel = last_channel ? ctrl_i.start_channel : channel + 4'h1;
                     end
                  endcase
               end
            end
         end
         ST_DONE:
         begin
            // Rearmed by dropping enable
            if (!ctrl_i.conversion_enable || !ctrl_i.converter_power_on)
            begin
               next_state = ST_IDLE;
            end
         end
         ST_HALTED:
         begin
            // Flag frozen while halted, its content is unreliable
            next_overflow = overflow;
            if (!ctrl_i.conversion_enable && !ctrl_i.converter_power_on)
            begin
               next_state = ST_IDLE;
            end
         end
         default:
         begin
            next_state = ST_IDLE;
         end
      endcase
      // Power removal aborts a conversion, but not a halt
      if (state != ST_HALTED && !ctrl_i.converter_power_on)
      begin
         next_state = ST_IDLE;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state <= ST_IDLE;
         tick_count <= TICK_RESET;
         channel <= CHAN_RESET;
         result_data_o <= DATA_RESET;
         result_channel_o <= CHAN_RESET;
         result_valid_o <= 1'b0;
         unread <= 1'b0;
         overflow <= 1'b0;
      end
      else
      begin
         state <= next_state;
         tick_count <= next_tick_count;
         channel <= next_channel;
         result_data_o <= next_result_data;
         result_channel_o <= next_result_channel;
         result_valid_o <= next_result_valid;
         unread <= next_unread;
         overflow <= next_overflow;
      end
   end

   assign conversion_busy_flag_o = busy;
   assign current_channel_o = channel;
   assign conversion_timer_overflow_flag_o = overflow;
   assign halted_o = (state == ST_HALTED);

endmodule

//--- verification/acs_sequencer_props.sv
// Concurrent checks on the conversion sequencer ports
`timescale 1ns/100ps
module acs_sequencer_chk
   import acs_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire acs_ctrl_t ctrl_i,
   input wire logic software_start_conversion_i,
   input wire logic timer_trigger_i,
   input wire logic [DATA_W-1:0] analog_data_i,
   input wire logic conversion_busy_flag_o,
   input wire logic result_valid_o,
   input wire logic [DATA_W-1:0] result_data_o,
   input wire logic conversion_timer_overflow_flag_o,
   input wire logic halted_o,
   input wire logic converter_hung_o
);
   wire logic trig = ctrl_i.trigger_from_timer ? timer_trigger_i : software_start_conversion_i;
   wire logic busy = conversion_busy_flag_o;
   wire logic live = ctrl_i.converter_power_on && ctrl_i.conversion_enable;
   wire logic any_on = ctrl_i.converter_power_on || ctrl_i.conversion_enable;
   wire logic multi = ctrl_i.conversion_sequence_mode != SEQ_SINGLE;
   wire logic ovf = conversion_timer_overflow_flag_o;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(trig))
      else $error("busy rose without a trigger");
   AST_END_RESULT: assert property ($fell(busy) && live && !halted_o |-> result_valid_o)
      else $error("busy fell without a result");
   AST_VALID_NOT_BUSY: assert property (result_valid_o |-> !busy && $past(busy))
      else $error("result not at end of busy");
   AST_DATA: assert property (result_valid_o |-> result_data_o == $past(analog_data_i))
      else $error("result data not captured");
   AST_HALT_HOLD: assert property (halted_o && any_on |=> halted_o)
      else $error("halt left without disable");
   AST_HALT_QUIET: assert property (halted_o |-> !result_valid_o && !busy)
      else $error("activity while halted");
   AST_HALT_CAUSE: assert property ($rose(halted_o) |-> $past(busy && trig && multi))
      else $error("halt without early trigger");
   AST_SINGLE_IGNORE: assert property (busy && trig && !multi |=> !halted_o)
      else $error("single mode halted");
   AST_OVF_FROZEN: assert property (halted_o ##1 halted_o |-> $stable(ovf))
      else $error("overflow flag moved while halted");
   AST_HUNG_STICKY: assert property (converter_hung_o |=> converter_hung_o)
      else $error("hang cleared without reset");
   AST_HUNG_IDLE: assert property (converter_hung_o && !busy |=> !result_valid_o)
      else $error("result while hung");
   cover property ($rose(halted_o));
   cover property (result_valid_o);
   cover property ($rose(converter_hung_o));
endmodule
bind acs_sequencer acs_sequencer_chk u_chk (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
   .ctrl_i(ctrl_i), .software_start_conversion_i(software_start_conversion_i),
   .timer_trigger_i(timer_trigger_i), .analog_data_i(analog_data_i),
   .conversion_busy_flag_o(conversion_busy_flag_o), .result_valid_o(result_valid_o),
   .result_data_o(result_data_o), .halted_o(halted_o), .converter_hung_o(converter_hung_o),
   .conversion_timer_overflow_flag_o(conversion_timer_overflow_flag_o));

//--- verification/acs_host_model.sv
// Host side model: clock source ticks and periodic timer trigger
`timescale 1ns/100ps
module acs_host_model
(
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic timer_run_i,
   input wire logic [7:0] timer_period_i,
   output logic [3:0] source_tick_o,
   output logic timer_trigger_o
);
   logic [7:0] count;
   logic [7:0] next_count;
   logic [1:0] phase;
   logic [1:0] next_phase;
   always_comb
   begin
      next_phase = phase + 2'h1;
      next_count = (!timer_run_i || count == timer_period_i) ? 8'h00 : count + 8'h01;
   end
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         count <= 8'h00;
         phase <= 2'h0;
      end
      else
      begin
         count <= next_count;
         phase <= next_phase;
      end
   end
   // Sub-main source ticks every second cycle
   assign source_tick_o = {phase[0], phase == 2'h0, phase == 2'h0, 1'b1};
   assign timer_trigger_o = timer_run_i && count == timer_period_i;
endmodule

//--- verification/tb.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
module tb
   import acs_pkg::*;
;
   logic clk, rst_n, sw, ttrig, sample_hold_input, rd, trun, busy, rv, ovf, halted, hung, got;
   logic [3:0] tick, rch;
   logic [7:0] tper;
   logic [11:0] adata, rdata;
   logic [31:0] seed;
   acs_ctrl_t ctrl;
   acs_clk_cfg_t ccfg;
   int n_errors, tests_run;
   acs_sequencer dut (.sys_clk_i(clk), .reset_n_i(rst_n), .ctrl_i(ctrl), .clk_cfg_i(ccfg),
      .source_tick_i(tick), .software_start_conversion_i(sw), .timer_trigger_i(ttrig),
      .sample_hold_input_i(sample_hold_input), .analog_data_i(adata), .result_read_i(rd),
      .conversion_busy_flag_o(busy), .result_valid_o(rv), .result_data_o(rdata),
      .result_channel_o(rch), .current_channel_o(), .conversion_timer_overflow_flag_o(ovf),
      .halted_o(halted), .converter_hung_o(hung));
   acs_host_model model (.sys_clk_i(clk), .reset_n_i(rst_n), .timer_run_i(trun),
      .timer_period_i(tper), .source_tick_o(tick), .timer_trigger_o(ttrig));
   function logic exp_hang(input logic g, input logic [2:0] d);
      return g && (({1'b0, d} + 4'h1) inside {4'h3, 4'h5, 4'h7});
   endfunction
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task nr();
      seed = xorshift(seed);
   endtask
   task print_verdict();
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      tests_run++;
      if (g !== e)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task trig();
      nr();
      adata = seed[11:0];
      sw = 1'b1;
      cyc(1);
      sw = 1'b0;
   endtask
   task res();
      got = 1'b0;
      for (int i = 0; i < 300 && !got; i++)
      begin
         cyc(1);
         got = rv === 1'b1;
      end
   endtask
   task want(input logic [3:0] ch);
      res();
      chk("result_valid", 12'h001, {11'h000, got});
      if (!got)
         print_verdict();
      chk("result_data", adata, rdata);
      chk("result_channel", {8'h00, ch}, {8'h00, rch});
   endtask
   task restart();
      ctrl.conversion_enable = 1'b0;
      ctrl.converter_power_on = 1'b0;
      cyc(1);
      ctrl.converter_power_on = 1'b1;
      cyc(1);
      ctrl.conversion_enable = 1'b1;
      cyc(2);
   endtask
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      {rst_n, sw, sample_hold_input, rd, trun, tper, adata, n_errors, tests_run} = '0;
      ctrl = '0;
      ccfg = '0;
      seed = 32'h140f;
      cyc(5);
      rst_n = 1'b1;
      cyc(1);
      chk("reset_outputs", 12'h000, {7'h00, busy, rv, ovf, halted, hung});
      ctrl.sample_pulse_mode_select = 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         nr();
         ctrl.start_channel = seed[7:4];
         ctrl.sample_clocks = {4'h0, seed[3:0]};
         restart();
         trig();
         chk("busy", 12'h001, {11'h000, busy});
         want(ctrl.start_channel);
      end
      ctrl.conversion_sequence_mode = SEQ_REPEAT_SINGLE;
      ctrl.trigger_from_timer = 1'b1;
      restart();
      tper = 8'h50;
      trun = 1'b1;
      repeat (2) want(ctrl.start_channel);
      trun = 1'b0;
      chk("halted", 12'h000, {11'h000, halted});
      ctrl.trigger_from_timer = 1'b0;
      ctrl.conversion_sequence_mode = SEQ_CHANNELS;
      ctrl.start_channel = 4'h2;
      ctrl.end_channel = 4'h4;
      restart();
      // Clear flags left by earlier unread results
      rd = 1'b1;
      cyc(1);
      rd = 1'b0;
      for (int c = 2; c < 5; c++)
      begin
         trig();
         want(c[3:0]);
         chk("overflow", {11'h000, c > 2}, {11'h000, ovf});
      end
      rd = 1'b1;
      cyc(1);
      rd = 1'b0;
      cyc(1);
      chk("overflow", 12'h000, {11'h000, ovf});
      ctrl.conversion_sequence_mode = SEQ_SINGLE;
      ctrl.sample_pulse_mode_select = 1'b0;
      restart();
      sample_hold_input = 1'b1;
      trig();
      cyc(20 + seed[3:0]);
      chk("busy", 12'h001, {11'h000, busy});
      sample_hold_input = 1'b0;
      want(4'h2);
      ctrl.sample_pulse_mode_select = 1'b1;
      ctrl.sample_clocks = 8'h08;
      for (int m = 0; m < 4; m++)
      begin
         ctrl.conversion_sequence_mode = m[1:0];
         restart();
         trig();
         cyc(2);
         trig();
         cyc(2);
         chk("halted", {11'h000, m != 0}, {11'h000, halted});
         if (m != 0)
         begin
            trig();
            res();
            chk("halted_result", 12'h000, {11'h000, got});
         end
         restart();
         trig();
         want(4'h2);
      end
      ctrl.conversion_sequence_mode = SEQ_SINGLE;
      for (int h = 0; h < 3; h++)
      begin
         ccfg = {h != 1, 2'h3, h == 0 ? 3'h1 : 3'h2};
         cyc(4);
         ccfg.converter_clock_select = 2'h0;
         cyc(4);
         chk("hung", {11'h000, exp_hang(ccfg[5], ccfg[2:0])}, {11'h000, hung});
      end
      restart();
      trig();
      res();
      chk("hung_result", 12'h000, {11'h000, got});
      rst_n = 1'b0;
      ccfg = '0;
      cyc(2);
      rst_n = 1'b1;
      cyc(1);
      chk("hung", 12'h000, {11'h000, hung});
      print_verdict();
   end
endmodule
